// File: verilog/s0dq_decode_top.sv
// source-0 doubleword decoder, direct quad-lane layout, with register slave
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Take source-0 operand and flag select from the third instruction word.
// - Pick layout by addressing and alignment; only direct quad-lane is decoded.
// - Bit 25 picks one of two sixteen-bit flag sub-registers.
// - With predication on, the picked sub-register gives the predication mask.
// - With condition modifier on, condition flags go to the picked sub-register.
// - With both on, one picked sub-register is source and destination.
// - Bits 24:21 give row pitch; ignored for an immediate source.
// - Bits 19:16 give lane swizzle bits 7:4; unused for an immediate.
// - Bit 15 gives operand addressing kind; ignored for an immediate.
// - Bits 14:13 give the operand value modifier; unused for an immediate.
// - Bits 12:5 give the operand register index; ignored for an immediate.
// - Bit 4 gives the 16-byte-aligned register offset; ignored for immediates.
// - Bits 3:0 give per-lane enables; ignored for an immediate.
module s0dq_decode_top
  import s0dq_pkg::*;
(
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  // instruction from fetch
  input  wire logic                  i_insn_valid,
  output logic                       o_insn_ready,
  input  wire logic [WORD_W-1:0]     i_third_instruction_word,
  input  wire logic                  i_src0_is_imm,
  input  wire logic                  i_direct_addressing,
  input  wire logic                  i_quad_lane_alignment,
  input  wire logic                  i_pred_en,
  input  wire logic                  i_cond_mod_en,
  // decoded operand
  output logic                       o_dec_valid,
  output logic                       o_layout_unsupported,
  output logic                       o_flag_bank_select,
  output logic [3:0]                 o_row_pitch,
  output logic [3:0]                 o_lane_swizzle_hi,
  output logic                       o_operand_addressing_kind,
  output logic [1:0]                 o_operand_value_modifier,
  output logic [7:0]                 o_operand_reg_index,
  output logic                       o_operand_reg_offset,
  output logic [3:0]                 o_operand_lane_enable,
  output logic                       o_pred_active,
  output logic [FLAG_BANK_W-1:0]     o_pred_mask,
  output logic                       o_cond_write_en,
  // condition results from execution
  input  wire logic                  i_cond_valid,
  input  wire logic [FLAG_BANK_W-1:0] i_cond_flags,
  // axi4-lite slave
  input  wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [WORD_W-1:0]     i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  output logic [WORD_W-1:0]          o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready
);

  typedef struct packed {
    logic                   ctrl_enable;
    logic                   rsvd_seen;
    logic                   unsup_seen;
    logic [WORD_W-1:0]      dec_count;
    logic                   dec_valid;
    logic                   unsup;
    logic                   flag_sel;
    logic [3:0]             row_pitch;
    logic [3:0]             swz_hi;
    logic                   addr_kind;
    logic [1:0]             vmod;
    logic [7:0]             reg_index;
    logic                   reg_offset;
    logic [3:0]             lane_en;
    logic                   pred_active;
    logic [FLAG_BANK_W-1:0] pred_mask;
    logic                   cond_en;
    logic                   aw_got;
    logic                   w_got;
    logic [AXI_ADDR_W-1:0]  aw_addr;
    logic [WORD_W-1:0]      w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [WORD_W-1:0]      rdata;
  } s0dq_state_s;

  s0dq_state_s st_reg;
  s0dq_state_s st_next;

  s0dq_fields_if fld ();
  s0dq_flag_if   flg ();

  // field extraction and flag storage
  s0dq_field_split u_split (
    .i_third_instruction_word (i_third_instruction_word),
    .i_src0_is_imm            (i_src0_is_imm),
    .fields                   (fld.src)
  );

  s0dq_flag_banks u_flags (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .flag_port  (flg.bank)
  );

  logic                  insn_take;
  logic                  layout_ok;
  logic                  aw_take;
  logic                  w_take;
  logic                  ar_take;
  logic                  wr_fire;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0]     wr_data;
  logic [3:0]            wr_strb;
  logic [WORD_W-1:0]     wr_merged;
  logic [WORD_W-1:0]     wr_old;
  logic [WORD_W-1:0]     status_word;

  // handshakes are combinational; disabled decoder stalls fetch
  assign insn_take       = i_insn_valid && st_reg.ctrl_enable;
  assign layout_ok       = i_direct_addressing && i_quad_lane_alignment;
  assign aw_take         = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take          = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_take         = i_s_axi_arvalid && o_s_axi_arready;
  assign wr_fire         = (st_reg.aw_got || aw_take) && (st_reg.w_got || w_take) &&
                           !st_reg.bvalid;
  assign wr_addr         = st_reg.aw_got ? st_reg.aw_addr : i_s_axi_awaddr;
  assign wr_data         = st_reg.w_got ? st_reg.w_data : i_s_axi_wdata;
  assign wr_strb         = st_reg.w_got ? st_reg.w_strb : i_s_axi_wstrb;
  assign status_word     = {29'h0, st_reg.dec_valid, st_reg.unsup_seen, st_reg.rsvd_seen};

  // old value of the addressed word, for byte-lane merging
  always_comb begin
    wr_old = '0;
    if (wr_addr[AXI_ADDR_W-1:2] == CTRL_OFS[AXI_ADDR_W-1:2]) begin
      wr_old = {31'h0, st_reg.ctrl_enable};
    end else if (wr_addr[AXI_ADDR_W-1:2] == FLAGS_OFS[AXI_ADDR_W-1:2]) begin
      wr_old = flg.banks;
    end
  end

  // one generate lane per byte strobe
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merged[8*b +: 8] = wr_strb[b] ? wr_data[8*b +: 8] : wr_old[8*b +: 8];
  end

  // flag sub-register hookup: read select from the incoming word, write select from the registered decode
  assign flg.rd_sel   = fld.flag_bank_select;
  assign flg.hw_wr    = i_cond_valid && st_reg.cond_en;
  assign flg.hw_sel   = st_reg.flag_sel;
  assign flg.hw_flags = i_cond_flags;
  assign flg.sw_wr    = wr_fire && (wr_addr[AXI_ADDR_W-1:2] == FLAGS_OFS[AXI_ADDR_W-1:2]);
  assign flg.sw_data  = wr_merged;

  // next state: decode stage, status, and bus slave
  always_comb begin
    st_next           = st_reg;
    st_next.dec_valid = 1'b0;
    st_next.unsup     = 1'b0;
    if (insn_take) begin
      if (layout_ok) begin
        st_next.dec_valid   = 1'b1;
        st_next.flag_sel    = fld.flag_bank_select;
        st_next.row_pitch   = fld.row_pitch;
        st_next.swz_hi      = fld.lane_swizzle_hi;
        st_next.addr_kind   = fld.operand_addressing_kind;
        st_next.vmod        = fld.operand_value_modifier;
        st_next.reg_index   = fld.operand_reg_index;
        st_next.reg_offset  = fld.operand_reg_offset;
        st_next.lane_en     = fld.operand_lane_enable;
        st_next.pred_active = i_pred_en;
        // unpredicated instructions run every lane
        st_next.pred_mask   = i_pred_en ? flg.rd_mask : PRED_ALL_LANES;
        st_next.cond_en     = i_cond_mod_en;
        st_next.dec_count   = st_reg.dec_count + 32'h1;
      end else begin
        // other layouts belong to sibling decoders; flag it, emit nothing
        st_next.unsup   = 1'b1;
        st_next.cond_en = 1'b0;
      end
    end

    // write channel: address and data in either order
    if (aw_take) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = i_s_axi_awaddr;
    end
    if (w_take) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = i_s_axi_wdata;
      st_next.w_strb = i_s_axi_wstrb;
    end
    if (st_reg.bvalid && i_s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OKAY;
      unique case (wr_addr[AXI_ADDR_W-1:2])
        CTRL_OFS[AXI_ADDR_W-1:2]: st_next.ctrl_enable = wr_merged[CTRL_ENABLE_BIT];
        STATUS_OFS[AXI_ADDR_W-1:2]: begin
          // write one to clear, but only in a strobed byte
          if (wr_strb[0] && wr_data[ST_RSVD_BIT]) begin
            st_next.rsvd_seen = 1'b0;
          end
          if (wr_strb[0] && wr_data[ST_UNSUP_BIT]) begin
            st_next.unsup_seen = 1'b0;
          end
        end
        COUNT_OFS[AXI_ADDR_W-1:2], FLAGS_OFS[AXI_ADDR_W-1:2]: st_next.bresp = RESP_OKAY;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end

    // sticky status: a new event beats a same-cycle clear
    if (insn_take && fld.reserved_nonzero) begin
      st_next.rsvd_seen = 1'b1;
    end
    if (insn_take && !layout_ok) begin
      st_next.unsup_seen = 1'b1;
    end

    // read channel: one-cycle answer
    if (st_reg.rvalid && i_s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      unique case (i_s_axi_araddr[AXI_ADDR_W-1:2])
        CTRL_OFS[AXI_ADDR_W-1:2]:   st_next.rdata = {31'h0, st_reg.ctrl_enable};
        STATUS_OFS[AXI_ADDR_W-1:2]: st_next.rdata = status_word;
        COUNT_OFS[AXI_ADDR_W-1:2]:  st_next.rdata = st_reg.dec_count;
        FLAGS_OFS[AXI_ADDR_W-1:2]:  st_next.rdata = flg.banks;
        default: begin
          st_next.rdata = '0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_reg             <= '0;
      st_reg.ctrl_enable <= CTRL_ENABLE_RST;
      st_reg.dec_count   <= COUNT_RST;
      st_reg.pred_mask   <= PRED_ALL_LANES;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign o_insn_ready              = st_reg.ctrl_enable;
  assign o_dec_valid               = st_reg.dec_valid;
  assign o_layout_unsupported      = st_reg.unsup;
  assign o_flag_bank_select        = st_reg.flag_sel;
  assign o_row_pitch               = st_reg.row_pitch;
  assign o_lane_swizzle_hi         = st_reg.swz_hi;
  assign o_operand_addressing_kind = st_reg.addr_kind;
  assign o_operand_value_modifier  = st_reg.vmod;
  assign o_operand_reg_index       = st_reg.reg_index;
  assign o_operand_reg_offset      = st_reg.reg_offset;
  assign o_operand_lane_enable     = st_reg.lane_en;
  assign o_pred_active             = st_reg.pred_active;
  assign o_pred_mask               = st_reg.pred_mask;
  assign o_cond_write_en           = st_reg.cond_en;
  assign o_s_axi_awready           = !st_reg.aw_got && !st_reg.bvalid;
  assign o_s_axi_wready            = !st_reg.w_got && !st_reg.bvalid;
  assign o_s_axi_bvalid            = st_reg.bvalid;
  assign o_s_axi_bresp             = st_reg.bresp;
  assign o_s_axi_arready           = !st_reg.rvalid;
  assign o_s_axi_rvalid            = st_reg.rvalid;
  assign o_s_axi_rdata             = st_reg.rdata;
  assign o_s_axi_rresp             = st_reg.rresp;

  // checks on the decode stage
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  flag_select_a: assert property (
    o_dec_valid |-> o_flag_bank_select == $past(i_third_instruction_word[FLAG_SEL_BIT]))
    else $error("flag select differs from bit 25");
  row_pitch_a: assert property (
    o_dec_valid |-> o_row_pitch == ($past(i_src0_is_imm) ? 4'h0 :
                                    $past(i_third_instruction_word[PITCH_HI:PITCH_LO])))
    else $error("row pitch wrong");
  swizzle_hi_a: assert property (
    o_dec_valid && !$past(i_src0_is_imm) |->
      o_lane_swizzle_hi == $past(i_third_instruction_word[SWZ_HI:SWZ_LO]))
    else $error("swizzle bits wrong");
  addr_kind_a: assert property (
    o_dec_valid && !$past(i_src0_is_imm) |->
      o_operand_addressing_kind == $past(i_third_instruction_word[ADDR_KIND_BIT]))
    else $error("addressing kind wrong");
  value_mod_a: assert property (
    o_dec_valid && !$past(i_src0_is_imm) |->
      o_operand_value_modifier == $past(i_third_instruction_word[VMOD_HI:VMOD_LO]))
    else $error("value modifier wrong");
  reg_index_a: assert property (
    o_dec_valid && !$past(i_src0_is_imm) |->
      o_operand_reg_index == $past(i_third_instruction_word[REG_HI:REG_LO]))
    else $error("register index wrong");
  reg_offset_a: assert property (
    o_dec_valid |-> o_operand_reg_offset ==
      (!$past(i_src0_is_imm) && $past(i_third_instruction_word[OFFS_BIT])))
    else $error("register offset wrong");
  lane_enable_a: assert property (
    o_dec_valid && !$past(i_src0_is_imm) |->
      o_operand_lane_enable == $past(i_third_instruction_word[LANE_HI:LANE_LO]))
    else $error("lane enable wrong");
  pred_mask_a: assert property (
    o_dec_valid && o_pred_active |->
      o_pred_mask == $past(flg.banks[16*i_third_instruction_word[FLAG_SEL_BIT] +: 16]))
    else $error("predication mask not from selected bank");
  cond_write_a: assert property (
    i_cond_valid && o_cond_write_en |=> flg.banks[16*$past(o_flag_bank_select) +: 16] ==
      $past(i_cond_flags))
    else $error("condition flags not stored in selected bank");
  layout_gate_a: assert property (
    insn_take && !layout_ok |=> o_layout_unsupported && !o_dec_valid)
    else $error("unsupported layout decoded");

  imm_decode_c:  cover property (o_dec_valid && $past(i_src0_is_imm));
  pred_cond_c:   cover property (o_dec_valid && o_pred_active && o_cond_write_en ##1 i_cond_valid);
  unsupported_c: cover property (o_layout_unsupported);
  bus_write_c:   cover property (wr_fire && flg.sw_wr);

endmodule

// File: verilog/s0dq_pkg.sv
// constants and types shared by the source-0 quad-lane direct decoder
package s0dq_pkg;

  // instruction word geometry
  localparam int WORD_W        = 32;
  localparam int RSVD_TOP_HI   = 31;
  localparam int RSVD_TOP_LO   = 26;
  localparam int FLAG_SEL_BIT  = 25;
  localparam int PITCH_HI      = 24;
  localparam int PITCH_LO      = 21;
  localparam int RSVD_MID_BIT  = 20;
  localparam int SWZ_HI        = 19;
  localparam int SWZ_LO        = 16;
  localparam int ADDR_KIND_BIT = 15;
  localparam int VMOD_HI       = 14;
  localparam int VMOD_LO       = 13;
  localparam int REG_HI        = 12;
  localparam int REG_LO        = 5;
  localparam int OFFS_BIT      = 4;
  localparam int LANE_HI       = 3;
  localparam int LANE_LO       = 0;

  // flag register: two sub-registers of sixteen flags each
  localparam int FLAG_BANK_W = 16;
  localparam int FLAG_BANKS  = 2;
  localparam logic [FLAG_BANK_W-1:0] FLAG_BANK_RST  = 16'h0000;
  localparam logic [FLAG_BANK_W-1:0] PRED_ALL_LANES = 16'hFFFF;

  // register bus map (byte addresses)
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] COUNT_OFS  = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] FLAGS_OFS  = 8'h0C;

  // field positions and reset values inside the registers
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam logic CTRL_ENABLE_RST = 1'h1;
  localparam int ST_RSVD_BIT       = 0;
  localparam int ST_UNSUP_BIT      = 1;
  localparam int ST_OUT_VALID_BIT  = 2;
  localparam logic [WORD_W-1:0] COUNT_RST = 32'h0000_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operand addressing kind carried in the word
  typedef enum logic {
    S0DQ_ADDR_DIRECT,
    S0DQ_ADDR_INDIRECT
  } s0dq_addr_kind_e;

endpackage

// File: verilog/s0dq_if.sv
// carriers between the decoder core and its helper modules
`timescale 1ns/1ps

// operand fields pulled out of the third instruction word
interface s0dq_fields_if;
  logic       flag_bank_select;
  logic [3:0] row_pitch;
  logic [3:0] lane_swizzle_hi;
  logic       operand_addressing_kind;
  logic [1:0] operand_value_modifier;
  logic [7:0] operand_reg_index;
  logic       operand_reg_offset;
  logic [3:0] operand_lane_enable;
  logic       reserved_nonzero;
  modport src (output flag_bank_select, row_pitch, lane_swizzle_hi, operand_addressing_kind,
               operand_value_modifier, operand_reg_index, operand_reg_offset,
               operand_lane_enable, reserved_nonzero);
  modport dst (input flag_bank_select, row_pitch, lane_swizzle_hi, operand_addressing_kind,
               operand_value_modifier, operand_reg_index, operand_reg_offset,
               operand_lane_enable, reserved_nonzero);
endinterface

// access to the two flag sub-registers
interface s0dq_flag_if;
  logic        rd_sel;
  logic [15:0] rd_mask;
  logic        hw_wr;
  logic        hw_sel;
  logic [15:0] hw_flags;
  logic        sw_wr;
  logic [31:0] sw_data;
  logic [31:0] banks;
  modport bank (input rd_sel, hw_wr, hw_sel, hw_flags, sw_wr, sw_data,
                output rd_mask, banks);
  modport user (output rd_sel, hw_wr, hw_sel, hw_flags, sw_wr, sw_data,
                input rd_mask, banks);
endinterface

// File: verilog/s0dq_field_split.sv
// field extraction for the direct quad-lane layout of the third word
`timescale 1ns/1ps

module s0dq_field_split
  import s0dq_pkg::*;
(
  // word and operand kind
  input  wire logic [WORD_W-1:0] i_third_instruction_word,
  input  wire logic              i_src0_is_imm,
  // split fields
  s0dq_fields_if.src             fields
);

  // flag select is not an operand field, so an immediate never masks it
  assign fields.flag_bank_select = i_third_instruction_word[FLAG_SEL_BIT];

  // operand fields read as zero for an immediate source
  always_comb begin
    fields.row_pitch               = '0;
    fields.lane_swizzle_hi         = '0;
    fields.operand_addressing_kind = S0DQ_ADDR_DIRECT;
    fields.operand_value_modifier  = '0;
    fields.operand_reg_index       = '0;
    fields.operand_reg_offset      = 1'b0;
    fields.operand_lane_enable     = '0;
    if (!i_src0_is_imm) begin
      fields.row_pitch               = i_third_instruction_word[PITCH_HI:PITCH_LO];
      fields.lane_swizzle_hi         = i_third_instruction_word[SWZ_HI:SWZ_LO];
      fields.operand_addressing_kind = i_third_instruction_word[ADDR_KIND_BIT];
      fields.operand_value_modifier  = i_third_instruction_word[VMOD_HI:VMOD_LO];
      fields.operand_reg_index       = i_third_instruction_word[REG_HI:REG_LO];
      fields.operand_reg_offset      = i_third_instruction_word[OFFS_BIT];
      fields.operand_lane_enable     = i_third_instruction_word[LANE_HI:LANE_LO];
    end
  end

  // loose bits only feed a status flag, never the operand controls
  assign fields.reserved_nonzero =
    (|i_third_instruction_word[RSVD_TOP_HI:RSVD_TOP_LO]) |
    i_third_instruction_word[RSVD_MID_BIT];

endmodule

// File: verilog/s0dq_flag_banks.sv
// the two sixteen-bit flag sub-registers
`timescale 1ns/1ps

module s0dq_flag_banks
  import s0dq_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  // bank access
  s0dq_flag_if.bank flag_port
);

  typedef struct packed {
    logic [FLAG_BANKS-1:0][FLAG_BANK_W-1:0] bank;
  } s0dq_bank_s;

  s0dq_bank_s st_reg;
  s0dq_bank_s st_next;

  // software preload first, so a same-cycle condition result wins
  always_comb begin
    st_next = st_reg;
    if (flag_port.sw_wr) begin
      st_next.bank = flag_port.sw_data;
    end
    if (flag_port.hw_wr) begin
      st_next.bank[flag_port.hw_sel] = flag_port.hw_flags;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_reg <= '{bank: {FLAG_BANKS{FLAG_BANK_RST}}};
    end else begin
      st_reg <= st_next;
    end
  end

  // predication mask from the chosen sub-register
  assign flag_port.rd_mask = st_reg.bank[flag_port.rd_sel];
  assign flag_port.banks   = st_reg.bank;

endmodule

// File: verification/s0dq_fetch_model.sv
// fetch stage stand-in: offers one instruction and holds it until taken
`timescale 1ns/1ps
module s0dq_fetch_model (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // bench request and decoder handshake
  input  wire logic        i_insn_ready,
  input  wire logic        i_req,
  input  wire logic [31:0] i_word,
  input  wire logic [4:0]  i_ctl,
  // offered instruction
  output logic             o_insn_valid,
  output logic [31:0]      o_word,
  output logic [4:0]       o_ctl
);
  // idle word flips every cycle so stale data is never mistaken for a held word
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_insn_valid <= 1'b0;
    end else if (i_req) begin
      o_insn_valid <= 1'b1;
      o_word       <= i_word & 32'h03EF_FFFF;
      o_ctl        <= i_ctl;
    end else begin
      if (o_insn_valid && i_insn_ready) o_insn_valid <= 1'b0;
      if (!o_insn_valid) o_word <= ~o_word;
    end
  end
endmodule

// File: verification/tb.sv
// self-checking bench for the source-0 quad-lane direct decoder
`timescale 1ns/1ps
module tb;
  import s0dq_pkg::*;
  logic i_core_clk = 0, i_reset = 1, req = 0, i_cond_valid = 0, i_s_axi_awvalid = 0;
  logic i_s_axi_wvalid = 0, i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [31:0] wrd = 0, i_s_axi_wdata = 0, r = 32'hAC4C, fl = 0, i_third_instruction_word;
  logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, o_operand_reg_index;
  logic [4:0] ctl = 0, mc;
  logic [3:0] i_s_axi_wstrb = 0, o_row_pitch, o_lane_swizzle_hi, o_operand_lane_enable;
  logic [15:0] i_cond_flags = 0, o_pred_mask;
  logic [1:0] o_operand_value_modifier, o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata;
  logic i_insn_valid, o_insn_ready, o_dec_valid, o_layout_unsupported, o_flag_bank_select;
  logic o_operand_addressing_kind, o_operand_reg_offset, o_pred_active, o_cond_write_en;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire logic i_src0_is_imm, i_direct_addressing, i_quad_lane_alignment, i_pred_en, i_cond_mod_en;
  logic [47:0] q[$];
  int num_errors = 0, n_compared = 0, i;
  assign {i_src0_is_imm, i_direct_addressing, i_quad_lane_alignment, i_pred_en, i_cond_mod_en} = mc;
  always #12.5 i_core_clk = ~i_core_clk;
  s0dq_decode_top uut (.*);
  s0dq_fetch_model fetch (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_insn_ready(o_insn_ready),
    .i_req(req), .i_word(wrd), .i_ctl(ctl), .o_insn_valid(i_insn_valid),
    .o_word(i_third_instruction_word), .o_ctl(mc));
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // queue the expected decode, then hand the word to the fetch model
  task automatic send(input logic [31:0] w, input logic [4:0] c);
    int n;
    logic [15:0] b;
    b = w[25] ? fl[31:16] : fl[15:0];
    if (c[3:2] != 2'h3) q.push_back('1);
    else q.push_back({1'b0, c[1] ? b : 16'hFFFF, 6'h0, w[25], c[4] ? 24'h0 : {w[24:21], w[19:0]}});
    @(posedge i_core_clk) req <= 1'b1;
    wrd <= w;
    ctl <= c;
    @(posedge i_core_clk) req <= 1'b0;
    for (n = 0; n < 20; n++) @(negedge i_core_clk) if (!i_insn_valid) break;
    if (n == 20) begin
      num_errors++;
      summarize;
    end
  endtask
  // one register access; each channel released at its own handshake edge
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] p);
    int n;
    logic [3:0] t;
    if (!w) q.push_back({14'h0, p, d});
    @(posedge i_core_clk);
    if (w) {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_wstrb} <= {a, d, 4'hF};
    if (w) {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    else {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'h3};
    t = 0;
    for (n = 0; n < 20 && !t[0]; n++) begin
      @(negedge i_core_clk);
      t = {o_s_axi_awready & i_s_axi_awvalid, o_s_axi_wready & i_s_axi_wvalid,
           o_s_axi_arready & i_s_axi_arvalid, w ? o_s_axi_bvalid : o_s_axi_rvalid};
      @(posedge i_core_clk);
      if (t[3]) i_s_axi_awvalid <= 1'b0;
      if (t[2]) i_s_axi_wvalid <= 1'b0;
      if (t[1]) i_s_axi_arvalid <= 1'b0;
      if (t[0]) {i_s_axi_bready, i_s_axi_rready} <= 2'h0;
    end
    if (!t[0]) begin
      num_errors++;
      summarize;
    end
  endtask
  // results leave the queue in issue order; unexpected results meet an unknown
  always @(negedge i_core_clk) begin
    if (o_dec_valid || o_layout_unsupported)
      chk(o_layout_unsupported ? '1 : {1'b0, o_pred_mask, 6'h0, o_flag_bank_select, o_row_pitch,
          o_lane_swizzle_hi, o_operand_addressing_kind, o_operand_value_modifier,
          o_operand_reg_index, o_operand_reg_offset, o_operand_lane_enable},
          q.size() ? q.pop_front() : 'x);
    if (o_s_axi_rvalid && i_s_axi_rready)
      chk({14'h0, o_s_axi_rresp, o_s_axi_rdata}, q.size() ? q.pop_front() : 'x);
  end
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    ax(1, FLAGS_OFS, r, 0);
    fl = r;
    for (i = 0; i < 16; i++) begin
      r = lf(r);
      send(r, {r[31], 2'h3, r[30], 1'b0});
    end
    $display("random decode with predication done");
    for (i = 0; i < 3; i++) send(r, {1'b0, i[1:0], 2'h0});
    $display("other layouts done");
    // condition flags land in the selected bank only when enabled; i odd has both on
    for (i = 0; i < 4; i++) begin
      r = lf(r);
      send(r, {3'h3, 1'b1, i[0]});
      @(posedge i_core_clk) {i_cond_valid, i_cond_flags} <= {1'b1, r[15:0]};
      @(posedge i_core_clk) i_cond_valid <= 1'b0;
      if (i[0]) fl = r[25] ? {r[15:0], fl[15:0]} : {fl[31:16], r[15:0]};
      ax(0, FLAGS_OFS, fl, RESP_OKAY);
    end
    $display("condition writes done");
    ax(0, 8'h10, 0, RESP_SLVERR);
    ax(1, CTRL_OFS, 0, 0);
    @(negedge i_core_clk) chk(o_insn_ready, 0);
    ax(1, CTRL_OFS, 1, 0);
    send(r, 5'h1C);
    $display("bus refusal and immediate source done");
    summarize;
  end
endmodule
